// ==== verilog/adcl_pkg.sv ====
// Purpose: shared constants and types of the limit match flag block
// Assumes: 16-bit register port, byte addresses as decoded by the top
// Notes:   an odd address selects the high byte of a 16-bit register
package adcl_pkg;

	// ****************************************************************
	// sizes
	// ****************************************************************
	localparam int unsigned ADCL_CHANNELS = 14;
	localparam int unsigned ADCL_RES_W    = 12; // result bits d15..d4
	localparam int unsigned ADCL_ADDR_W   = 16;
	localparam int unsigned ADCL_DATA_W   = 16;

	// ****************************************************************
	// register byte addresses
	// ****************************************************************
	localparam logic [15:0] ADCL_STATUS_ADDR   = 16'hF826;
	localparam logic [15:0] ADCL_CLEAR_ADDR    = 16'hF82A;
	localparam logic [15:0] ADCL_CTRL_ADDR     = 16'hF830;
	localparam logic [15:0] ADCL_IRQ_STAT_ADDR = 16'hF832;
	localparam logic [15:0] ADCL_IRQ_MASK_ADDR = 16'hF834;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int unsigned ADCL_CTRL_EN_BIT   = 0;
	localparam int unsigned ADCL_CTRL_TIM_BIT  = 4;
	localparam int unsigned ADCL_CTRL_COND_LSB = 8;
	localparam int unsigned ADCL_IRQ_REQ_BIT   = 0; // limit request rose
	localparam int unsigned ADCL_IRQ_SET_BIT   = 1; // a flag newly set
	localparam int unsigned ADCL_IRQ_BITS      = 2;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [13:0] ADCL_FLAGS_RST    = 14'h0000;
	localparam logic [15:0] ADCL_RDATA_RST    = 16'h0000;
	localparam logic [1:0]  ADCL_IRQ_STAT_RST = 2'h0;
	localparam logic [1:0]  ADCL_IRQ_MASK_RST = 2'h0;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [1:0] {
		ADCL_COND_INSIDE  = 2'h0,
		ADCL_COND_ABOVE   = 2'h1,
		ADCL_COND_BELOW   = 2'h2,
		ADCL_COND_OUTSIDE = 2'h3
	} adcl_cond_t;

	typedef struct packed {
		logic                  limit_detect_enable;
		logic                  interrupt_timing_select;
		adcl_cond_t            limit_condition_select;
	} adcl_ctrl_t;

	localparam adcl_ctrl_t ADCL_CTRL_RST = '{1'b0, 1'b0, ADCL_COND_INSIDE};

	typedef struct packed {
		logic                  valid;   // one-cycle conversion done
		logic [3:0]            channel;
		logic [ADCL_RES_W-1:0] value;
	} adcl_result_t;

endpackage : adcl_pkg

// ==== verilog/adcl_limit_compare.sv ====
// Purpose: compare one conversion result against the limit window
// Assumes: limits and result are unsigned, same 12-bit scale
// Notes:   purely combinational, the caller registers the outcome
`timescale 1ns/1ns
`default_nettype none
module adcl_limit_compare (
	input  wire  logic [11:0]          result_i,
	input  wire  logic [11:0]          upper_i,
	input  wire  logic [11:0]          lower_i,
	input  wire  adcl_pkg::adcl_cond_t cond_i,
	output logic                       match_o
);
	import adcl_pkg::*;

	logic above;
	logic below;

	// strict compares, so the inside window includes both limits
	assign above = result_i > upper_i;
	assign below = result_i < lower_i;

	// condition select picks one of four tests
	always_comb begin
		unique case (cond_i)
			ADCL_COND_INSIDE:  match_o = !above && !below;
			ADCL_COND_ABOVE:   match_o = above;
			ADCL_COND_BELOW:   match_o = below;
			ADCL_COND_OUTSIDE: match_o = above || below;
		endcase
	end

endmodule : adcl_limit_compare
`default_nettype wire

// ==== verilog/adcl_flag_bank.sv ====
// Purpose: sticky per-channel match flags
// Assumes: set and clear vectors are one-cycle pulses on clk_i
// Notes:   a set in the same cycle as a clear leaves the flag set while enable_i is high
`timescale 1ns/1ns
`default_nettype none
module adcl_flag_bank (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        enable_i,
	input  wire logic [13:0] set_i,
	input  wire logic [13:0] clr_i,
	output logic      [13:0] flags_o
);
	import adcl_pkg::*;

	// ****************************************************************
	// one flag per channel
	// ****************************************************************
	for (genvar ch = 0; ch < ADCL_CHANNELS; ch++) begin : g_flag
		logic flag_reg;
		logic flag_next;
		logic set_ok;

		// updates only while detection is on; clear still works off
		assign set_ok = set_i[ch] && enable_i;

		// sticky hold, ones-only clear, set beats clear
		always_comb begin
			flag_next = flag_reg;
			if (clr_i[ch]) begin
				flag_next = 1'b0;
			end
			if (set_ok) begin
				flag_next = 1'b1;
			end
		end // non-matching results never touch the flag

		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				flag_reg <= ADCL_FLAGS_RST[ch];
			end else begin
				flag_reg <= flag_next;
			end
		end

		assign flags_o[ch] = flag_reg;
	end

endmodule : adcl_flag_bank
`default_nettype wire

// ==== verilog/adcl_limit_match.sv ====
// Purpose: limit match status, clear, control and interrupt logic
// Assumes: result path and register port run on clk_i
// Notes:   read data appear one cycle after the read strobe only
`timescale 1ns/1ns
`default_nettype none
// Operation
// - read-only status, channels 0-13, bits 15:14 zero
// - flag set on match, zero after reset
// - writing one to clear bit clears flag
// - flag stays set until clear or reset
// - enabled detection requests interrupt on any flag
// - clearing flags or reset removes pending request
// - write-only clear register, bits 13-0 channels
// - writing zero to clear bit does nothing
// - disabled detection never updates match flags; here clear writes still drop flags while disabled
// - condition field selects inside, above, below, outside
module adcl_limit_match (
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	// register port
	input  wire logic [15:0]          addr_i,
	input  wire logic [15:0]          wdata_i,
	input  wire logic                 wr_i,
	input  wire logic                 rd_i,
	output logic      [15:0]          rdata_o,
	// converter result path
	input  wire adcl_pkg::adcl_result_t result_i,
	input  wire logic                 scan_done_i,
	input  wire logic [11:0]          upper_limit_value_i,
	input  wire logic [11:0]          lower_limit_value_i,
	// flags and requests
	output logic      [13:0]          limit_match_flags_o,
	output logic                      limit_irq_req_o,
	output logic                      irq_o
);
	import adcl_pkg::*;

	// ****************************************************************
	// address decode
	// ****************************************************************
	logic hit_stat_lo;
	logic hit_stat_hi;
	logic hit_clr_lo;
	logic hit_clr_hi;
	logic hit_ctrl_lo;
	logic hit_ctrl_hi;
	logic hit_istat_lo;
	logic hit_istat_hi;
	logic hit_imask_lo;
	logic hit_imask_hi;

	// an odd address reaches the high byte in data bits 7:0
	assign hit_stat_lo  = addr_i == ADCL_STATUS_ADDR;
	assign hit_stat_hi  = addr_i == ADCL_STATUS_ADDR + 16'h0001;
	assign hit_clr_lo   = addr_i == ADCL_CLEAR_ADDR;
	assign hit_clr_hi   = addr_i == ADCL_CLEAR_ADDR + 16'h0001;
	assign hit_ctrl_lo  = addr_i == ADCL_CTRL_ADDR;
	assign hit_ctrl_hi  = addr_i == ADCL_CTRL_ADDR + 16'h0001;
	assign hit_istat_lo = addr_i == ADCL_IRQ_STAT_ADDR;
	assign hit_istat_hi = addr_i == ADCL_IRQ_STAT_ADDR + 16'h0001;
	assign hit_imask_lo = addr_i == ADCL_IRQ_MASK_ADDR;
	assign hit_imask_hi = addr_i == ADCL_IRQ_MASK_ADDR + 16'h0001;

	// ****************************************************************
	// control register
	// ****************************************************************
	adcl_ctrl_t  ctrl_reg;
	adcl_ctrl_t  ctrl_next;
	logic [15:0] ctrl_word;
	logic [15:0] ctrl_wr_word;

	// control fields laid out as a 16-bit word for reads and merges
	always_comb begin
		ctrl_word = 16'h0000;
		ctrl_word[ADCL_CTRL_EN_BIT]  = ctrl_reg.limit_detect_enable;
		ctrl_word[ADCL_CTRL_TIM_BIT] = ctrl_reg.interrupt_timing_select;
		ctrl_word[ADCL_CTRL_COND_LSB +: 2] = ctrl_reg.limit_condition_select;
	end

	// byte writes merge into the word, reserved bits are dropped
	always_comb begin
		ctrl_wr_word = ctrl_word;
		if (wr_i && hit_ctrl_lo) begin
			ctrl_wr_word = wdata_i;
		end else if (wr_i && hit_ctrl_hi) begin
			ctrl_wr_word = {wdata_i[7:0], ctrl_word[7:0]};
		end
		ctrl_next.limit_detect_enable     = ctrl_wr_word[ADCL_CTRL_EN_BIT];
		ctrl_next.interrupt_timing_select = ctrl_wr_word[ADCL_CTRL_TIM_BIT];
		ctrl_next.limit_condition_select  =
			adcl_cond_t'(ctrl_wr_word[ADCL_CTRL_COND_LSB +: 2]);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg <= ADCL_CTRL_RST;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	// ****************************************************************
	// match detection and flags
	// ****************************************************************
	logic        res_match;
	logic        res_in_range;
	logic [13:0] set_vec;
	logic [13:0] clr_vec;
	logic [13:0] flags;

	adcl_limit_compare u_compare (
		.result_i (result_i.value),
		.upper_i  (upper_limit_value_i),
		.lower_i  (lower_limit_value_i),
		.cond_i   (ctrl_reg.limit_condition_select),
		.match_o  (res_match)
	);

	// channels above 13 (test channel) never reach a flag
	assign res_in_range = result_i.channel < 4'(ADCL_CHANNELS);

	// one-hot set for the converted channel when it matched
	always_comb begin
		set_vec = 14'h0000;
		if (result_i.valid && res_in_range && res_match) begin
			set_vec = 14'(14'h0001 << result_i.channel);
		end
	end

	// clear register is write-only, only bits written as one act
	always_comb begin
		clr_vec = 14'h0000;
		if (wr_i && hit_clr_lo) begin
			clr_vec = wdata_i[13:0];
		end else if (wr_i && hit_clr_hi) begin
			clr_vec = {wdata_i[5:0], 8'h00};
		end
	end

	adcl_flag_bank u_flags (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.enable_i (ctrl_reg.limit_detect_enable),
		.set_i    (set_vec),
		.clr_i    (clr_vec),
		.flags_o  (flags)
	);

	assign limit_match_flags_o = flags;

	// ****************************************************************
	// limit interrupt request and its timing
	// ****************************************************************
	logic any_flag;
	logic pending_reg;
	logic pending_next;
	logic req_reg;
	logic req_next;

	assign any_flag = |flags;

	// timing select 0: request as soon as a flag is set;
	// timing select 1: request only from the end of a scan onward.
	// both forms drop once every flag is cleared, so software never
	// has to acknowledge the request beyond the flags themselves
	always_comb begin
		pending_next = ctrl_reg.limit_detect_enable && any_flag &&
			(pending_reg || scan_done_i);
		req_next = ctrl_reg.limit_detect_enable && any_flag &&
			(!ctrl_reg.interrupt_timing_select || pending_next);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pending_reg <= 1'b0;
			req_reg     <= 1'b0;
		end else begin
			pending_reg <= pending_next;
			req_reg     <= req_next;
		end
	end

	assign limit_irq_req_o = req_reg;

	// ****************************************************************
	// interrupt status and mask
	// ****************************************************************
	logic [1:0] istat_reg;
	logic [1:0] istat_next;
	logic [1:0] imask_reg;
	logic [1:0] imask_next;
	logic [1:0] ievent;
	logic       irq_reg;
	logic       irq_next;

	// events: request rising, and any flag newly set
	always_comb begin
		ievent = 2'h0;
		ievent[ADCL_IRQ_REQ_BIT] = req_next && !req_reg;
		ievent[ADCL_IRQ_SET_BIT] = ctrl_reg.limit_detect_enable &&
			|(set_vec & ~flags);
	end

	// a read clears the status, a same-cycle event still lands
	always_comb begin
		istat_next = istat_reg;
		if (rd_i && hit_istat_lo) begin
			istat_next = 2'h0;
		end
		istat_next = istat_next | ievent;
		imask_next = imask_reg;
		if (wr_i && hit_imask_lo) begin
			imask_next = wdata_i[1:0];
		end
		irq_next = |(istat_next & imask_next);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			istat_reg <= ADCL_IRQ_STAT_RST;
			imask_reg <= ADCL_IRQ_MASK_RST;
			irq_reg   <= 1'b0;
		end else begin
			istat_reg <= istat_next;
			imask_reg <= imask_next;
			irq_reg   <= irq_next;
		end
	end

	assign irq_o = irq_reg;

	// ****************************************************************
	// read data
	// ****************************************************************
	logic [15:0] rdata_reg;
	logic [15:0] rdata_next;

	// data stand for exactly one cycle; unmapped and write-only read 0
	always_comb begin
		rdata_next = ADCL_RDATA_RST;
		if (rd_i) begin
			if (hit_stat_lo) begin
				rdata_next = {2'b00, flags};
			end else if (hit_stat_hi) begin
				rdata_next = {10'h000, flags[13:8]};
			end else if (hit_ctrl_lo) begin
				rdata_next = ctrl_word;
			end else if (hit_ctrl_hi) begin
				rdata_next = {8'h00, ctrl_word[15:8]};
			end else if (hit_istat_lo) begin
				rdata_next = {14'h0000, istat_reg};
			end else if (hit_imask_lo) begin
				rdata_next = {14'h0000, imask_reg};
			end
			// clear register and upper bytes of irq regs read zero
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_reg <= ADCL_RDATA_RST;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign rdata_o = rdata_reg;

	// hit_istat_hi and hit_imask_hi drive no read logic; those addresses read zero by default
	logic unused_hits;
	assign unused_hits = hit_istat_hi ^ hit_imask_hi ^ hit_clr_lo;

endmodule : adcl_limit_match
`default_nettype wire

// ==== tb/adcl_limit_match_sva.sv ====
// Purpose: port-level checks of the limit match flag block
// Assumes: one clock domain, synchronous reset
// Notes:   limit condition and enable are internal, so only port relations
`timescale 1ns/1ns
`default_nettype none
module adcl_limit_match_sva (
	input wire logic                   clk_i,
	input wire logic                   rst_i,
	input wire logic [15:0]            addr_i,
	input wire logic [15:0]            wdata_i,
	input wire logic                   wr_i,
	input wire logic                   rd_i,
	input wire logic [15:0]            rdata_o,
	input wire adcl_pkg::adcl_result_t result_i,
	input wire logic [13:0]            limit_match_flags_o,
	input wire logic                   limit_irq_req_o,
	input wire logic                   irq_o
);
	import adcl_pkg::*;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic clr_w;
	// even-address clear write, the only one tied to the low flag bits
	assign clr_w = wr_i && addr_i == ADCL_CLEAR_ADDR;

	a_status_read_word: assert property (rd_i && addr_i == ADCL_STATUS_ADDR |=>
		rdata_o == {2'b00, $past(limit_match_flags_o)}) else $error("status read wrong");
	a_rdata_idle_zero: assert property (!rd_i |=> rdata_o == 16'h0000)
		else $error("read data not idle zero");
	a_clear_reads_zero: assert property (rd_i && addr_i == ADCL_CLEAR_ADDR |=>
		rdata_o == 16'h0000) else $error("clear register readable");
	a_flag_stays_set: assert property (!(wr_i && addr_i[15:1] == ADCL_CLEAR_ADDR[15:1]) |=>
		(limit_match_flags_o & $past(limit_match_flags_o)) == $past(limit_match_flags_o))
		else $error("flag dropped without clear");
	a_zero_bits_keep: assert property (clr_w |=> ((limit_match_flags_o
		& $past(limit_match_flags_o & ~wdata_i[13:0])) == $past(limit_match_flags_o
		& ~wdata_i[13:0]))) else $error("zero clear bit changed a flag");
	a_one_bits_clear: assert property (clr_w && !result_i.valid |=>
		(limit_match_flags_o & $past(wdata_i[13:0])) == 14'h0000) else $error("flag not cleared");
	a_set_needs_valid: assert property ((limit_match_flags_o & ~$past(limit_match_flags_o))
		!= 14'h0000 |-> $past(result_i.valid) && ((limit_match_flags_o
		& ~$past(limit_match_flags_o)) == (14'h0001 << $past(result_i.channel))))
		else $error("flag set without matching result");
	a_req_needs_flag: assert property (limit_irq_req_o |->
		$past(limit_match_flags_o) != 14'h0000) else $error("request with no flag");

	c_collision: cover property (clr_w && result_i.valid);
	c_req_rise: cover property ($rose(limit_irq_req_o));
	c_irq_rise: cover property ($rose(irq_o));
endmodule : adcl_limit_match_sva
bind adcl_limit_match adcl_limit_match_sva u_sva (.clk_i(clk_i), .rst_i(rst_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.result_i(result_i), .limit_match_flags_o(limit_match_flags_o),
	.limit_irq_req_o(limit_irq_req_o), .irq_o(irq_o));
`default_nettype wire

// ==== tb/adcl_conv_model.sv ====
// Purpose: converter result path model feeding the flag block
// Assumes: one result one cycle after a start pulse
// Notes:   idle result fields toggle so stale values never look valid
`timescale 1ns/1ns
`default_nettype none
module adcl_conv_model (
	input  wire logic                   clk_i,
	input  wire logic                   start_i,
	input  wire logic [3:0]             ch_i,
	input  wire logic [11:0]            val_i,
	input  wire logic                   scan_i,
	output adcl_pkg::adcl_result_t      result_o,
	output logic                        scan_done_o
);
	import adcl_pkg::*;
	initial result_o = '0;
	initial scan_done_o = 1'b0;
	// one-cycle result pulse, inverted fields while idle
	always @(posedge clk_i) begin
		if (start_i) result_o <= '{1'b1, ch_i, val_i};
		else result_o <= '{1'b0, ~result_o.channel, ~result_o.value};
		scan_done_o <= scan_i;
	end
endmodule : adcl_conv_model
`default_nettype wire

// ==== tb/tb.sv ====
// Purpose: self-checking bench of the limit match flag block
// Assumes: reads checked through a queue of expected words
// Notes:   level outputs are checked one step after the edge
`timescale 1ns/1ns
`default_nettype none
module tb;
	import adcl_pkg::*;
	logic clk = 0, rst_i = 1, wr_i = 0, rd_i = 0, start = 0, scan = 0, rd_q = 0;
	logic [15:0] addr_i = 0, wdata_i = 0, rdata_o, exp_q[$];
	logic [11:0] up = 12'h0fff, lo = 0, val = 0;
	logic [3:0] ch = 0;
	logic [13:0] flags_o, fm = 0;
	logic req_o, irq_o, scan_done, en = 0;
	adcl_result_t res;
	int err_count = 0, tests_run = 0, cyc = 0, cond = 0;
	adcl_conv_model conv_m (.clk_i(clk), .start_i(start), .ch_i(ch), .val_i(val),
		.scan_i(scan), .result_o(res), .scan_done_o(scan_done));
	adcl_limit_match DUT (.clk_i(clk), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .result_i(res), .scan_done_i(scan_done),
		.upper_limit_value_i(up), .lower_limit_value_i(lo), .limit_match_flags_o(flags_o),
		.limit_irq_req_o(req_o), .irq_o(irq_o));
	always #10 clk = ~clk;
	task give_verdict;
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : give_verdict
	task check(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : check
	function logic hit(input int c, input logic [11:0] v);
		case (c)
			0: hit = v >= lo && v <= up;
			1: hit = v > up;
			2: hit = v < lo;
			default: hit = v > up || v < lo;
		endcase
	endfunction : hit
	// strobes drop with a spare edge so no signal is set twice in one step
	task wr_reg(input logic [15:0] a, input logic [15:0] d);
		addr_i <= a; wdata_i <= d; wr_i <= 1;
		@(posedge clk) wr_i <= 0;
		@(posedge clk);
	endtask : wr_reg
	task rd_reg(input logic [15:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		addr_i <= a; rd_i <= 1;
		@(posedge clk) rd_i <= 0;
		@(posedge clk);
	endtask : rd_reg
	// one conversion, optionally with a clear write landing on the same edge
	task conv(input logic [3:0] c, input logic [11:0] v, input logic [15:0] clr);
		ch <= c; val <= v; start <= 1;
		@(posedge clk) start <= 0;
		if (clr != 0) begin
			addr_i <= ADCL_CLEAR_ADDR; wdata_i <= clr; wr_i <= 1;
		end
		@(posedge clk) wr_i <= 0;
		@(posedge clk);
		fm = (fm & ~clr[13:0]) | (14'(hit(cond, v) & en) << c);
	endtask : conv
	// read data stand one cycle after the strobe edge
	always @(posedge clk) begin
		if (rd_q) check(rdata_o, exp_q.pop_front());
		rd_q <= rd_i;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			give_verdict();
		end
	end
	initial begin
		void'($urandom(32'h3e41));
		repeat (6) @(posedge clk);
		rst_i <= 0;
		@(posedge clk);
		rd_reg(ADCL_STATUS_ADDR, 16'h0000);
		rd_reg(ADCL_CLEAR_ADDR, 16'h0000);
		rd_reg(16'hf900, 16'h0000);
		conv(3, 12'h0100, 0);
		rd_reg(ADCL_STATUS_ADDR, {2'b00, fm});
		en = 1;
		// every condition code with random limits and results
		for (cond = 0; cond < 4; cond++) begin
			wr_reg(ADCL_CTRL_ADDR, 16'(1 + (cond << 8)));
			for (int i = 0; i < 6; i++) begin
				up <= 12'($urandom);
				lo <= 12'($urandom);
				conv(4'($urandom % 14), 12'($urandom), 0);
				rd_reg(ADCL_STATUS_ADDR, {2'b00, fm});
			end
			wr_reg(ADCL_CLEAR_ADDR, 16'h3fff);
			fm = 0;
			rd_reg(ADCL_STATUS_ADDR, 16'h0000);
		end
		cond = 1;
		wr_reg(ADCL_CTRL_ADDR, 16'h0101);
		up <= 12'h0800;
		lo <= 12'h0100;
		conv(5, 12'h0900, 0);
		conv(5, 12'h0000, 0);
		rd_reg(ADCL_STATUS_ADDR, 16'h0020);
		wr_reg(ADCL_CLEAR_ADDR, 16'h0000);
		conv(9, 12'h0900, 0);
		wr_reg(16'hf82b, 16'h0002);
		fm[9] = 1'b0; // high-byte clear bit 1 drops channel 9 from the model
		rd_reg(ADCL_STATUS_ADDR, 16'h0020);
		conv(5, 12'h0900, 16'h0020);
		rd_reg(ADCL_STATUS_ADDR, {2'b00, fm});
		conv(6, 12'h0000, 16'h0020);
		rd_reg(ADCL_STATUS_ADDR, {2'b00, fm});
		// interrupt raised, masked through bit 0, cleared
		rd_reg(ADCL_IRQ_STAT_ADDR, 16'h0003);
		wr_reg(ADCL_IRQ_MASK_ADDR, 16'h0001);
		conv(2, 12'h0900, 0);
		#1 check(16'(req_o), 16'h0001);
		check(16'(irq_o), 16'h0001);
		@(posedge clk);
		wr_reg(ADCL_CLEAR_ADDR, 16'h0004);
		#1 check(16'(req_o), 16'h0000);
		@(posedge clk);
		rd_reg(ADCL_IRQ_STAT_ADDR, 16'h0003);
		#1 check(16'(irq_o), 16'h0000);
		@(posedge clk);
		// request deferred to the end of scan
		wr_reg(ADCL_CTRL_ADDR, 16'h0111);
		conv(4, 12'h0900, 0);
		#1 check(16'(req_o), 16'h0000);
		@(posedge clk);
		scan <= 1;
		@(posedge clk) scan <= 0;
		repeat (4) @(posedge clk);
		#1 check(16'(req_o), 16'h0001);
		repeat (2) @(posedge clk);
		give_verdict();
	end
endmodule : tb
`default_nettype wire
